// ===== dltp_top.sv
// Dual legacy counter/timer pair with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "dltp_params.svh"
module dltp_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dltp_pkg::dltp_pins_t pins,
   output dltp_pkg::dltp_events_t events
);
   import dltp_pkg::*;

   // Register map, one byte per word index:
   //   0 control and status: run and overflow bits of both timers,
   //     low nibble kept as plain storage for the external event bits
   //   1 mode select: gate, counter select and mode field per timer
   //   2 clock control: clock selects and prescale field, others read zero
   //   3 and 4 timer A low and high byte
   //   5 and 6 timer B low and high byte
   //   7 flag acknowledge: writing ones clears overflow flags, reads zero
   // Index 8 and above answers with a slave error and changes nothing.
   // Only byte lane 0 carries data; upper read bits are always zero.

   // Control and count registers
   // ctrl holds run and flag bits of both timers in its upper nibble;
   // mode and clk_ctl are written only by software; the four count bytes
   // are written by software and advanced by the counting logic.
   logic [7:0] ctrl;
   logic [7:0] mode;
   logic [7:0] clk_ctl;
   logic [7:0] low_a;
   logic [7:0] high_a;
   logic [7:0] low_b;
   logic [7:0] high_b;

   // Two-flop synchronisers for pins; first stage feeds only the second
   // The third stage is a delayed copy used only for edge detection, so a
   // pin event reaches the counters two clocks after the pin moves.
   // Sources must hold each level two clocks or an edge can be lost.
   dltp_pins_t pins_s1;
   dltp_pins_t pins_s2;
   dltp_pins_t pins_d;
   always_ff @(posedge aclk) begin
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      pins_d <= pins_s2;
   end

   // Falling edge detect on synchronised pins
   // The stages carry no reset but settle well before reset ends, since
   // the pins keep being sampled while reset is held. A pin that idles
   // low after reset simply produces no edge until it first rises.
   wire fall_a = pins_d.count_a & ~pins_s2.count_a;
   wire fall_b = pins_d.count_b & ~pins_s2.count_b;
   wire fall_ext = pins_d.ext_clk & ~pins_s2.ext_clk;

   // Mode decode, shared by both timers
   // Both fields share one decoder so the encodings cannot drift apart;
   // code 11 means split for timer A and halt for timer B.
   function automatic dltp_mode_t dec_mode(input logic [1:0] f);
      case (f)
         2'b00: dec_mode = DLTP_M13;
         2'b01: dec_mode = DLTP_M16;
         2'b10: dec_mode = DLTP_M8R;
         default: dec_mode = DLTP_MSPLIT;
      endcase
   endfunction
   wire dltp_mode_t mode_a = dec_mode(mode[1:0]);
   wire dltp_mode_t mode_b = dec_mode(mode[5:4]);
   wire split = (mode_a == DLTP_MSPLIT);

   // Prescaler: a single divider whose terminal count follows the field
   // The divider runs free from reset and is never restarted by a timer,
   // so the first prescaled tick after enabling may come early by up to
   // one period. The trade keeps both timers on one shared phase.
   // Switching to a smaller divide is safe: the compare is greater-or-equal,
   // so a count beyond the new terminal value wraps at once.
   // The external source is counted in falling edges, eight per tick.
   logic [5:0] pre_cnt;
   logic [2:0] ext_cnt;
   wire [5:0] pre_top = (clk_ctl[1:0] == 2'b00) ? `DLTP_DIV_12 :
                        (clk_ctl[1:0] == 2'b01) ? `DLTP_DIV_4 : `DLTP_DIV_48;
   wire pre_ext = (clk_ctl[1:0] == 2'b11);
   wire sys_tick = (pre_cnt >= pre_top);
   wire ext_tick = fall_ext & (ext_cnt == `DLTP_DIV_EXT);
   wire pre_tick = pre_ext ? ext_tick : sys_tick;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt <= 6'h00;
         ext_cnt <= 3'h0;
      end else begin
         // Divider for the system clock codes
         pre_cnt <= sys_tick ? 6'h00 : pre_cnt + 6'h01;
         // Edge counter for the external code
         if (fall_ext) begin
            ext_cnt <= ext_cnt + 3'h1;
         end
      end
   end

   // Per-timer tick: pin edges when counting, else selected clock
   // Clock select is don't-care while counting pins; gating applies to
   // every source, so a closed gate also stops pin counting.
   // Gate inputs are read after synchronising, which delays a gate change
   // by two clocks; pulse widths measured by gating carry that offset
   // on both edges, so it cancels.
   function automatic logic src_tick(input logic cnt_sel, input logic clk_sel, input logic pin_fall,
                                     input logic ptick);
      src_tick = cnt_sel ? pin_fall : (clk_sel ? 1'b1 : ptick);
   endfunction
   function automatic logic gate_ok(input logic run, input logic gate_en, input logic gate_in);
      gate_ok = run & (~gate_en | gate_in);
   endfunction

   wire tick_a = src_tick(mode[`DLTP_MODE_CNT_A], clk_ctl[`DLTP_CLK_SEL_A], fall_a, pre_tick);
   wire en_a = gate_ok(ctrl[`DLTP_CTRL_RUN_A], mode[`DLTP_MODE_GATE_A], pins_s2.gate_a) & tick_a;
   // Timer B: in split its run comes from its mode, count pin ignored
   // Outside split, timer B has its own run bit, gate and counter select.
   // In split its run follows the mode field alone and it never sees its
   // count pin, though its gate still applies; mode three halts it in either case.
   wire tick_b = split ? src_tick(1'b0, clk_ctl[`DLTP_CLK_SEL_B], 1'b0, pre_tick)
                       : src_tick(mode[`DLTP_MODE_CNT_B], clk_ctl[`DLTP_CLK_SEL_B], fall_b, pre_tick);
   wire run_b_eff = split ? (mode_b != DLTP_MSPLIT) : ctrl[`DLTP_CTRL_RUN_B];
   wire en_b = gate_ok(run_b_eff, mode[`DLTP_MODE_GATE_B], pins_s2.gate_b) & tick_b & (mode_b != DLTP_MSPLIT);
   // Split high byte: clock only, enabled by timer B run bit
   // The high byte ignores counter select and gate of timer A, and has
   // no gate of its own.
   wire tick_h = clk_ctl[`DLTP_CLK_SEL_A] ? 1'b1 : pre_tick;
   wire en_h = split & ctrl[`DLTP_CTRL_RUN_B] & tick_h;

   // Counting step for one 16-bit pair
   // Result bit 16 is the wrap of the active width; bits 15..0 are the
   // next high and low bytes. In 13-bit mode the unused top bits of the
   // low byte are carried over untouched, which is why readers mask them.
   // In split mode only the low byte moves here; the high byte of timer A
   // has its own increment below because it runs on different controls.
   function automatic logic [16:0] step(input dltp_mode_t m, input logic [7:0] lo, input logic [7:0] hi);
      logic [12:0] c13;
      logic [15:0] c16;
      c13 = {hi, lo[4:0]} + 13'h0001;
      c16 = {hi, lo} + 16'h0001;
      case (m)
         DLTP_M13: step = {(c13 == 13'h0000), c13[12:5], lo[7:5], c13[4:0]};
         DLTP_M16: step = {(c16 == 16'h0000), c16};
         DLTP_M8R: step = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
         DLTP_MSPLIT: step = {(lo == 8'hFF), hi, lo + 8'h01};
         default: step = {1'b0, hi, lo};
      endcase
   endfunction
   // Next values and overflow conditions of each timer
   wire [16:0] nx_a = step(mode_a, low_a, high_a);
   wire [16:0] nx_b = step(mode_b, low_b, high_b);
   wire ovf_a = en_a & nx_a[16];
   wire ovf_b_raw = en_b & nx_b[16];
   wire ovf_h = en_h & (high_a == 8'hFF);
   // In split, timer B flag comes from timer A high byte
   wire set_b = split ? ovf_h : ovf_b_raw;

   // AXI4-Lite write path: take address and data in either order
   // Each half is latched as it arrives and its ready dropped, so the master
   // may offer address and data in either order or together. The write is
   // performed in the cycle both are held and no response is pending, and
   // the response comes out on the following edge. Readies rise again only
   // after the response is taken, which keeps one write in flight at most.
   // A cleared byte strobe makes the write a no-op that still answers OKAY.
   logic [3:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_wr = aw_held & w_held & ~s_axi_bvalid;
   wire wr_lane = do_wr & w_strb[0];
   wire [7:0] wb = w_data[7:0];
   wire wr_ctrl = wr_lane & (aw_addr == `DLTP_OFS_CTRL);
   wire wr_ack = wr_lane & (aw_addr == `DLTP_OFS_ACK);
   wire wr_low_a = wr_lane & (aw_addr == `DLTP_OFS_LOW_A);
   wire wr_high_a = wr_lane & (aw_addr == `DLTP_OFS_HIGH_A);
   wire wr_low_b = wr_lane & (aw_addr == `DLTP_OFS_LOW_B);
   wire wr_high_b = wr_lane & (aw_addr == `DLTP_OFS_HIGH_B);
   wire wr_ok = (aw_addr <= `DLTP_OFS_ACK);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         // Address half taken
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         // Data half taken
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // Both halves present: perform and answer
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         // Response taken: open both channels again
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Register writes and counting; hardware set wins over software clear
   // A flag set in the same cycle as a software clear or a control write
   // wins, since it is assigned last; losing an overflow would be worse
   // than a stale flag, which software clears again.
   // The acknowledge index stands in for the interrupt vector clearing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `DLTP_RESET_BYTE;
         mode <= `DLTP_RESET_BYTE;
         clk_ctl <= `DLTP_RESET_BYTE;
         low_a <= `DLTP_RESET_BYTE;
         high_a <= `DLTP_RESET_BYTE;
         low_b <= `DLTP_RESET_BYTE;
         high_b <= `DLTP_RESET_BYTE;
      end else begin
         // Configuration registers
         if (wr_lane & (aw_addr == `DLTP_OFS_MODE)) begin
            mode <= wb;
         end
         if (wr_lane & (aw_addr == `DLTP_OFS_CLK)) begin
            clk_ctl <= wb & `DLTP_CLK_MASK;
         end
         // Run bits written freely; counts untouched by them
         if (wr_ctrl) begin
            ctrl <= wb;
         end else if (wr_ack) begin
            ctrl[`DLTP_CTRL_OVF_A] <= ctrl[`DLTP_CTRL_OVF_A] & ~wb[0];
            ctrl[`DLTP_CTRL_OVF_B] <= ctrl[`DLTP_CTRL_OVF_B] & ~wb[1];
         end

         // Hardware flag sets
         if (ovf_a) begin
            ctrl[`DLTP_CTRL_OVF_A] <= 1'b1;
         end
         if (set_b) begin
            ctrl[`DLTP_CTRL_OVF_B] <= 1'b1;
         end

         // Timer A bytes
         // Software write beats a count in the same cycle
         if (wr_low_a) begin
            low_a <= wb;
         end else if (en_a) begin
            low_a <= nx_a[7:0];
         end
         if (wr_high_a) begin
            high_a <= wb;
         end else if (split ? en_h : en_a) begin
            high_a <= split ? high_a + 8'h01 : nx_a[15:8];
         end

         // Timer B bytes follow the same priority
         if (wr_low_b) begin
            low_b <= wb;
         end else if (en_b) begin
            low_b <= nx_b[7:0];
         end
         if (wr_high_b) begin
            high_b <= wb;
         end else if (en_b) begin
            high_b <= nx_b[15:8];
         end
      end
   end

   // Read path: one outstanding read, answered the cycle after address
   // Read data are captured with the address, so a count that moves while
   // the response waits does not tear; the value is the one at the take.
   // A refused index answers a slave error with zero data.
   wire [7:0] rd_byte = (s_axi_araddr == `DLTP_OFS_CTRL) ? ctrl :
                        (s_axi_araddr == `DLTP_OFS_MODE) ? mode :
                        (s_axi_araddr == `DLTP_OFS_CLK) ? clk_ctl :
                        (s_axi_araddr == `DLTP_OFS_LOW_A) ? low_a :
                        (s_axi_araddr == `DLTP_OFS_HIGH_A) ? high_a :
                        (s_axi_araddr == `DLTP_OFS_LOW_B) ? low_b :
                        (s_axi_araddr == `DLTP_OFS_HIGH_B) ? high_b : 8'h00;
   wire rd_ok = (s_axi_araddr <= `DLTP_OFS_ACK);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         // Take address, capture data and status
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
         // Response taken: accept next address
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Overflow pulses for baud or conversion triggers
   // Pulses last one clock and rise on the same edge that sets the flag.
   // In split mode the raw pulse still marks timer B wraps for triggers
   // even though its flag is not set by them.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         events <= '0;
      end else begin
         events.ovf_a <= ovf_a;
         events.ovf_b <= set_b;
         events.ovf_b_raw <= ovf_b_raw;
      end
   end
endmodule

// ===== dltp_params.svh
// Register offsets, field positions, reset values and prescale counts for the timer pair
`ifndef DLTP_PARAMS_SVH
`define DLTP_PARAMS_SVH
`define DLTP_OFS_CTRL 4'h0
`define DLTP_OFS_MODE 4'h1
`define DLTP_OFS_CLK 4'h2
`define DLTP_OFS_LOW_A 4'h3
`define DLTP_OFS_HIGH_A 4'h4
`define DLTP_OFS_LOW_B 4'h5
`define DLTP_OFS_HIGH_B 4'h6
`define DLTP_OFS_ACK 4'h7
`define DLTP_CTRL_RUN_A 4
`define DLTP_CTRL_OVF_A 5
`define DLTP_CTRL_RUN_B 6
`define DLTP_CTRL_OVF_B 7
`define DLTP_MODE_CNT_A 2
`define DLTP_MODE_GATE_A 3
`define DLTP_MODE_CNT_B 6
`define DLTP_MODE_GATE_B 7
`define DLTP_CLK_SEL_A 3
`define DLTP_CLK_SEL_B 4
`define DLTP_CLK_MASK 8'h1B
`define DLTP_RESET_BYTE 8'h00
`define DLTP_DIV_12 6'h0B
`define DLTP_DIV_4 6'h03
`define DLTP_DIV_48 6'h2F
`define DLTP_DIV_EXT 3'h7
`endif

// ===== dltp_pkg.sv
// Types shared by the timer pair
package dltp_pkg;
   typedef enum logic [3:0] {
      DLTP_M13 = 4'h1,
      DLTP_M16 = 4'h2,
      DLTP_M8R = 4'h4,
      DLTP_MSPLIT = 4'h8
   } dltp_mode_t;
   typedef struct packed {
      logic gate_a;
      logic gate_b;
      logic count_a;
      logic count_b;
      logic ext_clk;
   } dltp_pins_t;
   typedef struct packed {
      logic ovf_a;
      logic ovf_b;
      logic ovf_b_raw;
   } dltp_events_t;
endpackage

// ===== dltp_props.sv
// Bus handshake and event checks for the timer pair
`timescale 1ns/100ps
module dltp_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dltp_pkg::dltp_events_t events
);
   import dltp_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Both halves of a write taken on one edge
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // Answers stand until taken, and hold the path closed meanwhile
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
      else $error("read response dropped");
   b_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   r_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read response late");
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while response pending");
   bad_addr_a: assert property (rd_take and s_axi_araddr > 4'h7 |=> s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   reset_quiet_a: assert property ($rose(aresetn) |-> events == 3'h0 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("activity right after reset");
endmodule
bind dltp_top dltp_props i_dltp_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .events(events));

// ===== dltp_pins_model.sv
// Far side model: count pins, gate inputs and external clock
`timescale 1ns/100ps
module dltp_pins_model (
   input wire logic aclk,
   input wire logic gate_a,
   input wire logic gate_b,
   output dltp_pkg::dltp_pins_t pins
);
   import dltp_pkg::*;
   logic [1:0] cnt_pin = 2'h3;
   logic [1:0] ext_div = 2'h0;
   // External clock of four cycles, so its divide-by-8 tick comes every 32
   always @(posedge aclk) begin
      ext_div <= ext_div + 2'h1;
   end
   assign pins = '{gate_a: gate_a, gate_b: gate_b, count_a: cnt_pin[0], count_b: cnt_pin[1], ext_clk: ext_div[1]};
   // Idle high; each level held two cycles so the sampler never misses one
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         @(posedge aclk);
         cnt_pin[which] <= 1'h0;
         repeat (2) @(posedge aclk);
         cnt_pin[which] <= 1'h1;
         @(posedge aclk);
      end
   endtask
endmodule

// ===== dltp_top_test.sv
// Self-checking bench for the timer pair: registers, counting modes, split mode, prescaler
`timescale 1ns/100ps
module dltp_top_test;
   import dltp_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic arvalid = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic gate_a = 1'h1;
   logic gate_b = 1'h1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   dltp_pins_t pins;
   dltp_events_t events;
   int bad_count = 0;
   int checks = 0;
   int dv[5] = '{12, 4, 48, 32, 1};
   always #12.5 aclk = ~aclk;
   // Response ready held high throughout, which the bus allows
   dltp_top i_dltp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1), .pins(pins), .events(events));
   dltp_pins_model i_dltp_pins_model (.aclk(aclk), .gate_a(gate_a), .gate_b(gate_b), .pins(pins));
   // Bus cycles: hold each channel until taken, wait for the answer
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      d = rdata[7:0];
      r = rresp;
   endtask
   task automatic cmp(input logic [16:0] g, input logic [16:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic cmp_rng(input logic [15:0] g, input int e);
      checks++;
      if ($isunknown(g) || int'(g) < e - 4 || int'(g) > e + 4) begin
         bad_count++;
         $display("BAD %0t count %0d want near %0d", $time, g, e);
      end
   endtask
   // Step the counter n events in mode m; result is flag, high, low
   function automatic logic [16:0] expect_cnt(input int m, input logic [7:0] h, input logic [7:0] l, input int n);
      logic [7:0] eh = h;
      logic [7:0] el = l;
      logic f = 1'h0;
      repeat (n) begin
         case (m)
            0: begin
               {eh, el[4:0]} = {eh, el[4:0]} + 13'h1;
               f |= ({eh, el[4:0]} == 13'h0);
            end
            1: begin
               {eh, el} = {eh, el} + 16'h1;
               f |= ({eh, el} == 16'h0);
            end
            default: begin
               el = el + 8'h1;
               if (el == 8'h0) begin
                  el = eh;
                  f = 1'h1;
               end
            end
         endcase
      end
      return {f, eh, el};
   endfunction
   // Load, run on pin edges, read back count and flag, then clear
   task automatic run_case(input int t, input int m, input logic [7:0] h, input logic [7:0] l, input int n,
                           input logic gb, input logic gi);
      logic [16:0] e;
      logic [7:0] rl, rh, rc, mk;
      logic [1:0] rs;
      e = expect_cnt(m, h, l, (gb && !gi) ? 0 : n);
      mk = (m == 0) ? 8'h1F : 8'hFF;
      if (t == 0) gate_a <= gi;
      else gate_b <= gi;
      wr(4'h1, t ? {gb, 1'h1, 2'(m), 4'h0} : {4'h0, gb, 1'h1, 2'(m)});
      wr(4'(3 + 2 * t), l);
      wr(4'(4 + 2 * t), h);
      wr(4'h0, t ? 8'h40 : 8'h10);
      i_dltp_pins_model.pulse(t, n);
      repeat (6) @(posedge aclk);
      rd(4'(3 + 2 * t), rl, rs);
      rd(4'(4 + 2 * t), rh, rs);
      rd(4'h0, rc, rs);
      cmp({rc[5 + 2 * t], rh, rl & mk}, {e[16:8], e[7:0] & mk});
      wr(4'h7, 8'h03);
      rd(4'h0, rc, rs);
      cmp({9'h0, rc}, {9'h0, t ? 8'h40 : 8'h10});
      wr(4'h0, 8'h00);
   endtask
   task automatic final_report;
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge aclk);
      bad_count++;
      final_report;
   end
   // Main sequence
   initial begin
      logic [7:0] rb, rh;
      logic [1:0] rs;
      int k;
      void'($urandom(55541));
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      for (int i = 0; i < 3; i++) begin
         rd(4'(i), rb, rs);
         cmp({7'h0, rs, rb}, 17'h0);
      end
      wr(4'h2, 8'hFF);
      rd(4'h2, rb, rs);
      cmp({9'h0, rb}, 17'h1B);
      rd(4'h8, rb, rs);
      cmp({7'h0, rs, rb}, 17'h200);
      wr(4'h2, 8'h00);
      // Hand-picked wraps and a closed gate, then random starts
      run_case(0, 0, 8'hFF, 8'h1E, 2, 1'h0, 1'h1);
      run_case(1, 1, 8'hFF, 8'hFF, 1, 1'h1, 1'h1);
      run_case(0, 2, 8'hC0, 8'hFE, 4, 1'h0, 1'h0);
      run_case(1, 0, 8'h12, 8'h34, 3, 1'h1, 1'h0);
      repeat (12) run_case($urandom % 2, $urandom % 3, 8'($urandom), 8'($urandom), 1 + $urandom % 6, 1'($urandom), 1'($urandom));
      // Split: high byte of A runs on timer B's run bit and raises B's flag
      wr(4'h1, 8'h03);
      wr(4'h2, 8'h08);
      wr(4'h4, 8'hF0);
      wr(4'h0, 8'h40);
      k = 0;
      while (events.ovf_b !== 1'h1 && k < 1000) begin
         @(posedge aclk);
         k++;
      end
      rd(4'h0, rb, rs);
      cmp({15'h0, rb[7], rb[5]}, 17'h2);
      wr(4'h0, 8'h00);
      wr(4'h7, 8'h03);
      // Every prescale code, then the system clock, over one span
      for (int p = 0; p < 5; p++) begin
         wr(4'h1, 8'h01);
         wr(4'h3, 8'h00);
         wr(4'h4, 8'h00);
         wr(4'h2, p == 4 ? 8'h08 : 8'(p));
         wr(4'h0, 8'h10);
         repeat (960) @(posedge aclk);
         wr(4'h0, 8'h00);
         rd(4'h3, rb, rs);
         rd(4'h4, rh, rs);
         cmp_rng({rh, rb}, 960 / dv[p]);
      end
      final_report;
   end
endmodule
